// ==== ggp_edge_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface ggp_edge_if;
	logic lvl;
	logic rise;
	logic fall;
	modport src (output lvl, output rise, output fall);
	modport snk (input lvl, input rise, input fall);
endinterface
`default_nettype wire

// ==== ggp_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// bus master; faster clocks would outrun the port's filter latency
module ggp_host_model
#(
	parameter int HALF = 8
)
(
	input  wire logic clk,
	input  wire logic sdaWire,
	output logic      sclLine,
	output logic      sdaDrv
);
	logic spike;

	initial
	begin
		sclLine = 1'b1;
		sdaDrv = 1'b1;
		spike = 1'b0;
	end

	task automatic hcyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// also serves as repeated start; waits out a trailing acknowledge
	task automatic start();
		sdaDrv <= 1'b1;
		hcyc(HALF);
		sclLine <= 1'b1;
		hcyc(HALF);
		sdaDrv <= 1'b0;
		hcyc(HALF);
		sclLine <= 1'b0;
	endtask

	task automatic stop();
		hcyc(HALF / 2);
		sdaDrv <= 1'b0;
		hcyc(HALF / 2);
		sclLine <= 1'b1;
		hcyc(HALF);
		sdaDrv <= 1'b1;
		hcyc(HALF);
	endtask

	task automatic bitx(input logic b, output logic r);
		hcyc(HALF / 2);
		sdaDrv <= b;
		hcyc(HALF / 2);
		sclLine <= 1'b1;
		hcyc(HALF / 2);
		r = sdaWire;
		if (spike)
		begin
			sdaDrv <= ~b;
			hcyc(1);
			sdaDrv <= b;
		end
		hcyc(HALF / 2);
		sclLine <= 1'b0;
	endtask

	task automatic xbyte(input logic [7:0] d, input logic last,
		output logic [7:0] q, output logic ackSeen);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bitx(d[i], r);
			q[i] = r;
		end
		bitx(last, r);
		ackSeen = ~r;
	endtask
endmodule // ggp_host_model
`default_nettype wire

// ==== ggp_i2c_port.sv ====
`timescale 1ns/100ps
`default_nettype none
module ggp_i2c_port
#(
	parameter logic [7:0] PART_ID = 8'h005a // arbitrary identification value
)
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        ce,
	input  wire logic        sclIn,
	input  wire logic        sdaIn,
	output logic             sdaOut,
	output logic             sdaOe,
	input  wire logic        measValid,
	input  wire logic [15:0] measCount,
	input  wire logic [15:0] measCurrent,
	input  wire logic [15:0] measVoltage,
	input  wire logic [7:0]  measTemp,
	input  wire logic [7:0]  relaxCount,
	input  wire logic [15:0] ccAdjust,
	input  wire logic [15:0] vmAdjust,
	output logic             measReady,
	output logic [7:0]       modeReg,
	output logic [7:0]       ctrlReg,
	output logic             softResetPulse
);
	typedef struct packed {
		ggp_pkg::ggp_state_type fsm;
		logic [3:0]             bitCnt;
		logic [7:0]             shift;
		logic [7:0]             ptr;
		logic                   busy;
		logic                   sdaOut;
		logic                   sdaOe;
		logic                   measReady;
		logic                   softRst;
		ggp_pkg::ggp_regs_type  regs;
	} ggp_port_type;

	ggp_port_type state_ff;
	ggp_port_type nxt_state;

	ggp_edge_if sclIf ();
	ggp_edge_if sdaIf ();

	ggp_pin_filter u_scl_filter (
		.clk     (clk),
		.rst_b   (rst_b),
		.ce      (ce),
		.pinIn   (sclIn),
		.edgeOut (sclIf.src)
	);

	ggp_pin_filter u_sda_filter (
		.clk     (clk),
		.rst_b   (rst_b),
		.ce      (ce),
		.pinIn   (sdaIn),
		.edgeOut (sdaIf.src)
	);

	function automatic logic isMapped(input logic [7:0] a);
		if (a > ggp_pkg::CURVE_CHARGE_POINT_LAST)
			isMapped = 1'b0;
		else if (a == ggp_pkg::UNMAPPED_A)
			isMapped = 1'b0;
		else if (a == ggp_pkg::UNMAPPED_B)
			isMapped = 1'b0;
		else if (a == ggp_pkg::UNMAPPED_C)
			isMapped = 1'b0;
		else
			isMapped = 1'b1;
	endfunction

	function automatic logic isWritable(input logic [7:0] a);
		if (!isMapped(a))
			isWritable = 1'b0;
		else if (a >= ggp_pkg::CONVERSION_COUNT_PAIR
			&& a <= ggp_pkg::DIE_TEMPERATURE_REG)
			isWritable = 1'b0;
		else if (a == ggp_pkg::RELAX_COUNTER_VALUE)
			isWritable = 1'b0;
		else if (a == ggp_pkg::PART_TYPE_CODE)
			isWritable = 1'b0;
		else if (a >= ggp_pkg::COULOMB_ADJUST_PAIR
			&& a <= ggp_pkg::VOLTAGE_ADJUST_HIGH)
			isWritable = 1'b0;
		else
			isWritable = 1'b1;
	endfunction

	function automatic logic [7:0] rdByte(
		input ggp_pkg::ggp_regs_type r,
		input logic [7:0] a
	);
		rdByte = 8'h0000;
		if (a == ggp_pkg::PART_TYPE_CODE)
			rdByte = PART_ID;
		else if (isMapped(a))
			rdByte = r[a[6:0]];
	endfunction

	// byte under the pointer, ready for the shifter when a read byte starts
	logic [7:0] rdNext;
	assign rdNext = rdByte(state_ff.regs, state_ff.ptr);

	// put one byte into the map; covers soft reset and read-only addresses
	function automatic ggp_pkg::ggp_regs_type wrByte(
		input ggp_pkg::ggp_regs_type r,
		input logic [7:0] a,
		input logic [7:0] d
	);
		wrByte = r;
		if (a == ggp_pkg::CONTROL_STATUS_REG && d[ggp_pkg::CTRL_SOFT_RESET])
		begin
			wrByte = ggp_pkg::regDefaults();
		end
		else if (isWritable(a))
			wrByte[a[6:0]] = d;
	endfunction

	always_comb
	begin
		nxt_state = state_ff;
		nxt_state.softRst = 1'b0;
		// command bits last one cycle only
		nxt_state.regs[ggp_pkg::OPERATING_MODE_REG][ggp_pkg::MODE_FORCE_CC] =
			1'b0;
		nxt_state.regs[ggp_pkg::OPERATING_MODE_REG][ggp_pkg::MODE_FORCE_VM] =
			1'b0;
		nxt_state.regs[ggp_pkg::CONTROL_STATUS_REG][ggp_pkg::CTRL_COUNTER_RST] =
			1'b0;

		// updates only between transfers, so a burst read sees one snapshot
		if (measValid && !state_ff.busy)
		begin
			nxt_state.regs[ggp_pkg::CONVERSION_COUNT_PAIR] = measCount[7:0];
			nxt_state.regs[ggp_pkg::CONVERSION_COUNT_PAIR+8'h0001] =
				measCount[15:8];
			nxt_state.regs[ggp_pkg::BATTERY_CURRENT_PAIR] = measCurrent[7:0];
			nxt_state.regs[ggp_pkg::BATTERY_CURRENT_PAIR+8'h0001] =
				measCurrent[15:8];
			nxt_state.regs[ggp_pkg::BATTERY_VOLTAGE_PAIR] = measVoltage[7:0];
			nxt_state.regs[ggp_pkg::BATTERY_VOLTAGE_PAIR+8'h0001] =
				measVoltage[15:8];
			nxt_state.regs[ggp_pkg::DIE_TEMPERATURE_REG] = measTemp;
			nxt_state.regs[ggp_pkg::RELAX_COUNTER_VALUE] = relaxCount;
			nxt_state.regs[ggp_pkg::COULOMB_ADJUST_PAIR] = ccAdjust[7:0];
			nxt_state.regs[ggp_pkg::COULOMB_ADJUST_PAIR+8'h0001] =
				ccAdjust[15:8];
			nxt_state.regs[ggp_pkg::VOLTAGE_ADJUST_PAIR] = vmAdjust[7:0];
			nxt_state.regs[ggp_pkg::VOLTAGE_ADJUST_PAIR+8'h0001] =
				vmAdjust[15:8];
		end

		if (sclIf.lvl && sdaIf.fall)
		begin
			nxt_state.fsm = ggp_pkg::GGP_ADDR;
			nxt_state.bitCnt = '0;
			nxt_state.busy = 1'b1;
			nxt_state.sdaOe = 1'b0;
		end
		else if (sclIf.lvl && sdaIf.rise)
		begin
			nxt_state.fsm = ggp_pkg::GGP_IDLE;
			nxt_state.busy = 1'b0;
			nxt_state.sdaOe = 1'b0;
		end
		else if (sclIf.rise)
		begin
			// data is taken on the rising clock, msb arrives first
			case (state_ff.fsm)
				ggp_pkg::GGP_ADDR, ggp_pkg::GGP_REGADR, ggp_pkg::GGP_WDATA:
				begin
					nxt_state.shift = {state_ff.shift[6:0], sdaIf.lvl};
					nxt_state.bitCnt = state_ff.bitCnt + 4'h0001;
				end
				ggp_pkg::GGP_RDATA:
					nxt_state.bitCnt = state_ff.bitCnt + 4'h0001;
				ggp_pkg::GGP_ACK_R:
				begin
					if (sdaIf.lvl)
						nxt_state.fsm = ggp_pkg::GGP_IDLE;
				end
				default:
					nxt_state.fsm = state_ff.fsm;
			endcase
		end
		else if (sclIf.fall)
		begin
			case (state_ff.fsm)
				ggp_pkg::GGP_ADDR:
				begin
					if (state_ff.bitCnt == ggp_pkg::ACK_CLOCK)
					begin
						if (state_ff.shift[7:1] == ggp_pkg::DEV_ADDR7[6:0])
						begin
							nxt_state.fsm = ggp_pkg::GGP_ACK_ADDR;
							nxt_state.sdaOe = 1'b1;
						end
						else
							nxt_state.fsm = ggp_pkg::GGP_IDLE;
					end
				end
				ggp_pkg::GGP_ACK_ADDR:
				begin
					nxt_state.bitCnt = '0;
					if (state_ff.shift[0])
					begin
						nxt_state.fsm = ggp_pkg::GGP_RDATA;
						nxt_state.shift = rdNext;
						nxt_state.sdaOe = ~rdNext[7];
						nxt_state.ptr = state_ff.ptr + 8'h0001;
					end
					else
					begin
						nxt_state.fsm = ggp_pkg::GGP_REGADR;
						nxt_state.sdaOe = 1'b0;
					end
				end
				ggp_pkg::GGP_REGADR:
				begin
					if (state_ff.bitCnt == ggp_pkg::ACK_CLOCK)
					begin
						nxt_state.ptr = state_ff.shift;
						nxt_state.fsm = ggp_pkg::GGP_ACK_REG;
						nxt_state.sdaOe = 1'b1;
					end
				end
				ggp_pkg::GGP_WDATA:
				begin
					if (state_ff.bitCnt == ggp_pkg::ACK_CLOCK)
					begin
						nxt_state.regs = wrByte(nxt_state.regs, state_ff.ptr,
							state_ff.shift);
						nxt_state.softRst =
							state_ff.ptr == ggp_pkg::CONTROL_STATUS_REG
							&& state_ff.shift[ggp_pkg::CTRL_SOFT_RESET];
						nxt_state.ptr = state_ff.ptr + 8'h0001;
						nxt_state.fsm = ggp_pkg::GGP_ACK_W;
						nxt_state.sdaOe = 1'b1;
					end
				end
				ggp_pkg::GGP_ACK_REG, ggp_pkg::GGP_ACK_W:
				begin
					nxt_state.fsm = ggp_pkg::GGP_WDATA;
					nxt_state.bitCnt = '0;
					nxt_state.sdaOe = 1'b0;
				end
				ggp_pkg::GGP_RDATA:
				begin
					if (state_ff.bitCnt == ggp_pkg::ACK_CLOCK)
					begin
						nxt_state.fsm = ggp_pkg::GGP_ACK_R;
						nxt_state.sdaOe = 1'b0;
					end
					else
					begin
						nxt_state.shift = {state_ff.shift[6:0], 1'b0};
						nxt_state.sdaOe = ~state_ff.shift[6];
					end
				end
				ggp_pkg::GGP_ACK_R:
				begin
					nxt_state.fsm = ggp_pkg::GGP_RDATA;
					nxt_state.bitCnt = '0;
					nxt_state.shift = rdNext;
					nxt_state.sdaOe = ~rdNext[7];
					nxt_state.ptr = state_ff.ptr + 8'h0001;
				end
				default:
					nxt_state.fsm = state_ff.fsm;
			endcase
		end

		nxt_state.measReady = ~nxt_state.busy;
		nxt_state.sdaOut = 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			state_ff <= '0;
			state_ff.fsm <= ggp_pkg::GGP_IDLE;
			state_ff.measReady <= 1'b1;
			state_ff.regs <= ggp_pkg::regDefaults();
		end
		else if (ce)
			state_ff <= nxt_state;
	end

	// defaults also via the shared reset table
	assign sdaOut = state_ff.sdaOut;
	assign sdaOe = state_ff.sdaOe;
	assign measReady = state_ff.measReady;
	assign modeReg = state_ff.regs[ggp_pkg::OPERATING_MODE_REG];
	assign ctrlReg = state_ff.regs[ggp_pkg::CONTROL_STATUS_REG];
	assign softResetPulse = state_ff.softRst;
endmodule // ggp_i2c_port
`default_nettype wire

// ==== ggp_i2c_port_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module ggp_i2c_port_asserts
(
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       sclIn,
	input  wire logic       sdaIn,
	input  wire logic       sdaOut,
	input  wire logic       sdaOe,
	input  wire logic       measReady,
	input  wire logic [7:0] modeReg,
	input  wire logic [7:0] ctrlReg,
	input  wire logic       softResetPulse
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	a_reset_values: assert property ($rose(rst_b) |-> !sdaOe && measReady
		&& modeReg == ggp_pkg::MODE_DEFAULT
		&& ctrlReg == ggp_pkg::CTRL_DEFAULT)
		else $error("outputs not at defaults after reset");
	a_open_drain: assert property (sdaOut == 1'b0)
		else $error("data pin driven high");
	a_oe_scl_low: assert property ($changed(sdaOe) |-> !sclIn && !$past(sclIn))
		else $error("data drive changed while clock high");
	a_oe_holds: assert property ($rose(sdaOe) |-> sdaOe [*8])
		else $error("data drive dropped early");
	a_idle_quiet: assert property (measReady |-> !sdaOe)
		else $error("data driven while idle");
	a_start_busy: assert property ($fell(measReady) |-> sclIn && !sdaIn)
		else $error("transfer began without start condition");
	a_pulse_single: assert property (softResetPulse |=> !softResetPulse)
		else $error("soft reset pulse too long");
	a_soft_defaults: assert property (softResetPulse |-> ##[0:2]
		(ctrlReg == ggp_pkg::CTRL_DEFAULT && modeReg == ggp_pkg::MODE_DEFAULT))
		else $error("soft reset left registers off default");
	a_regs_by_bus: assert property ($changed(modeReg) || $changed(ctrlReg)
		|-> !$past(measReady))
		else $error("register changed outside a transfer");

	c_soft_reset: cover property (softResetPulse);
	c_ack: cover property ($rose(sdaOe));
	c_start: cover property ($fell(measReady));
endmodule // ggp_i2c_port_asserts
`default_nettype wire

// ==== ggp_pin_filter.sv ====
`timescale 1ns/100ps
`default_nettype none
// three-stage sampler; a change is taken once stages two and three agree,
// which also swallows single-sample spikes
module ggp_pin_filter
(
	input  wire logic     clk,
	input  wire logic     rst_b,
	input  wire logic     ce,
	input  wire logic     pinIn,
	ggp_edge_if.src       edgeOut
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
		logic rise;
		logic fall;
	} ggp_filt_type;

	ggp_filt_type state_ff;
	ggp_filt_type nxt_state;

	always_comb
	begin
		nxt_state = state_ff;
		nxt_state.s1 = pinIn;
		nxt_state.s2 = state_ff.s1;
		nxt_state.s3 = state_ff.s2;
		nxt_state.rise = 1'b0;
		nxt_state.fall = 1'b0;
		if (state_ff.s2 == state_ff.s3 && state_ff.s3 != state_ff.lvl)
		begin
			nxt_state.lvl = state_ff.s3;
			nxt_state.rise = state_ff.s3;
			nxt_state.fall = ~state_ff.s3;
		end
	end

	// idle bus level is high
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			state_ff <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b1,
				rise: 1'b0, fall: 1'b0};
		else if (ce)
			state_ff <= nxt_state;
	end

	assign edgeOut.lvl = state_ff.lvl;
	assign edgeOut.rise = state_ff.rise;
	assign edgeOut.fall = state_ff.fall;
endmodule // ggp_pin_filter
`default_nettype wire

// ==== ggp_pkg.sv ====
`default_nettype none
package ggp_pkg;
	localparam int REG_COUNT = 96;
	localparam logic [7:0] DEV_ADDR7 = 8'h0070;
	localparam logic [2:0] BITS_PER_BYTE = 3'h0;
	localparam logic [3:0] ACK_CLOCK = 4'h0008;

	// register offsets
	localparam logic [7:0] OPERATING_MODE_REG = 8'h0000;
	localparam logic [7:0] CONTROL_STATUS_REG = 8'h0001;
	localparam logic [7:0] CONVERSION_COUNT_PAIR = 8'h0004;
	localparam logic [7:0] BATTERY_CURRENT_PAIR = 8'h0006;
	localparam logic [7:0] BATTERY_VOLTAGE_PAIR = 8'h0008;
	localparam logic [7:0] DIE_TEMPERATURE_REG = 8'h000a;
	localparam logic [7:0] COULOMB_CONFIG_PAIR = 8'h000f;
	localparam logic [7:0] VOLTAGE_ALGO_PARAM_PAIR = 8'h0011;
	localparam logic [7:0] CHARGE_ALARM_LEVEL = 8'h0013;
	localparam logic [7:0] LOW_VOLT_ALARM_LEVEL = 8'h0014;
	localparam logic [7:0] RELAX_CURRENT_WINDOW = 8'h0015;
	localparam logic [7:0] RELAX_COUNTER_VALUE = 8'h0016;
	localparam logic [7:0] RELAX_COUNTER_LIMIT = 8'h0017;
	localparam logic [7:0] PART_TYPE_CODE = 8'h0018;
	localparam logic [7:0] UNMAPPED_A = 8'h0019;
	localparam logic [7:0] UNMAPPED_B = 8'h001a;
	localparam logic [7:0] COULOMB_ADJUST_PAIR = 8'h001b;
	localparam logic [7:0] VOLTAGE_ADJUST_PAIR = 8'h001d;
	localparam logic [7:0] VOLTAGE_ADJUST_HIGH = 8'h001e;
	localparam logic [7:0] UNMAPPED_C = 8'h001f;
	localparam logic [7:0] ALGO_SCRATCH_FIRST = 8'h0020;
	localparam logic [7:0] ALGO_SCRATCH_LAST = 8'h002f;
	localparam logic [7:0] CURVE_VOLTAGE_POINT_FIRST = 8'h0030;
	localparam logic [7:0] CURVE_CHARGE_POINT_FIRST = 8'h0050;
	localparam logic [7:0] CURVE_CHARGE_POINT_LAST = 8'h005f;

	// field positions
	localparam int MODE_GG_RUN = 4;
	localparam int MODE_FORCE_CC = 5;
	localparam int MODE_FORCE_VM = 6;
	localparam int CTRL_COUNTER_RST = 1;
	localparam int CTRL_SOFT_RESET = 4;

	// reset values
	localparam logic [7:0] MODE_DEFAULT = 8'h000b;
	localparam logic [7:0] CTRL_DEFAULT = 8'h0011;
	localparam logic [15:0] COULOMB_CONFIG_DEFAULT = 16'h018b;
	localparam logic [15:0] VOLTAGE_ALGO_DEFAULT = 16'h0141;
	localparam logic [7:0] CHARGE_ALARM_DEFAULT = 8'h0002;
	localparam logic [7:0] LOW_VOLT_ALARM_DEFAULT = 8'h00aa;
	localparam logic [7:0] CURRENT_WINDOW_DEFAULT = 8'h000a;
	localparam logic [7:0] RELAX_DEFAULT = 8'h0078;

	typedef logic [REG_COUNT-1:0][7:0] ggp_regs_type;

	typedef enum logic [3:0] {
		GGP_IDLE = 4'h0000,
		GGP_ADDR = 4'h0001,
		GGP_ACK_ADDR = 4'h0003,
		GGP_REGADR = 4'h0002,
		GGP_ACK_REG = 4'h0006,
		GGP_WDATA = 4'h0007,
		GGP_ACK_W = 4'h0005,
		GGP_RDATA = 4'h0004,
		GGP_ACK_R = 4'h000c
	} ggp_state_type;

	function automatic ggp_regs_type regDefaults();
		ggp_regs_type r;
		r = '0;
		r[OPERATING_MODE_REG] = MODE_DEFAULT;
		r[CONTROL_STATUS_REG] = CTRL_DEFAULT;
		r[COULOMB_CONFIG_PAIR] = COULOMB_CONFIG_DEFAULT[7:0];
		r[COULOMB_CONFIG_PAIR+8'h0001] = COULOMB_CONFIG_DEFAULT[15:8];
		r[VOLTAGE_ALGO_PARAM_PAIR] = VOLTAGE_ALGO_DEFAULT[7:0];
		r[VOLTAGE_ALGO_PARAM_PAIR+8'h0001] = VOLTAGE_ALGO_DEFAULT[15:8];
		r[CHARGE_ALARM_LEVEL] = CHARGE_ALARM_DEFAULT;
		r[LOW_VOLT_ALARM_LEVEL] = LOW_VOLT_ALARM_DEFAULT;
		r[RELAX_CURRENT_WINDOW] = CURRENT_WINDOW_DEFAULT;
		r[RELAX_COUNTER_VALUE] = RELAX_DEFAULT;
		r[RELAX_COUNTER_LIMIT] = RELAX_DEFAULT;
		return r;
	endfunction
endpackage
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	localparam logic [7:0] TB_PART_ID = 8'h3c; // arbitrary value
	logic        clk, rst_b, sclLine, sdaDrv, sdaWire, sdaOut, sdaOe;
	logic        measValid, measReady, softResetPulse, ce;
	logic [15:0] measCount, measCurrent, measVoltage, ccAdjust, vmAdjust;
	logic [7:0]  measTemp, relaxCount, modeReg, ctrlReg;
	int          num_errors = 0;
	int          compares = 0;
	int          pulses = 0;
	logic [7:0]  dflt[$] = {8'h0b, 8'h11, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00,
		8'h8b, 8'h01, 8'h41, 8'h01,
		8'h02, 8'haa, 8'h0a, 8'h78, 8'h78,
		TB_PART_ID, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	// open drain with pull-up
	assign sdaWire = sdaDrv & (~sdaOe | sdaOut);

	initial clk = 1'b0;
	always #5 clk = ~clk;
	always @(posedge clk) if (softResetPulse === 1'b1) pulses++;

	ggp_host_model host (.clk(clk), .sdaWire(sdaWire), .sclLine(sclLine),
		.sdaDrv(sdaDrv));

	ggp_i2c_port #(.PART_ID(TB_PART_ID)) DUT (.clk(clk), .rst_b(rst_b),
		.ce(ce), .sclIn(sclLine), .sdaIn(sdaWire), .sdaOut(sdaOut),
		.sdaOe(sdaOe), .measValid(measValid), .measCount(measCount),
		.measCurrent(measCurrent), .measVoltage(measVoltage),
		.measTemp(measTemp), .relaxCount(relaxCount), .ccAdjust(ccAdjust),
		.vmAdjust(vmAdjust), .measReady(measReady), .modeReg(modeReg),
		.ctrlReg(ctrlReg), .softResetPulse(softResetPulse));

	task automatic chk8(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chkBit(input string what, input logic exp, input logic got);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic wrRegs(input logic [6:0] dev, input logic [7:0] a,
		input logic [7:0] d[$], input logic expAck);
		logic [7:0] q;
		logic ack;
		host.start();
		host.xbyte({dev, 1'b0}, 1'b1, q, ack);
		chkBit("address ack", expAck, ack);
		if (ack)
		begin
			host.xbyte(a, 1'b1, q, ack);
			chkBit("register ack", 1'b1, ack);
			foreach (d[i])
			begin
				host.xbyte(d[i], 1'b1, q, ack);
				chkBit("data ack", 1'b1, ack);
			end
		end
		host.stop();
	endtask

	// chg: byte index after which measVoltage and measTemp move
	task automatic rdCheck(input logic [7:0] a, input logic [7:0] exp[$],
		input int chg);
		logic [7:0] b;
		logic ack;
		host.start();
		host.xbyte(8'he0, 1'b1, b, ack);
		host.xbyte(a, 1'b1, b, ack);
		host.start();
		host.xbyte(8'he1, 1'b1, b, ack);
		chkBit("read address ack", 1'b1, ack);
		foreach (exp[i])
		begin
			host.xbyte(8'hff, i == exp.size() - 1, b, ack);
			chk8("read byte", exp[i], b);
			if (i == chg)
			begin
				measVoltage <= 16'h0bad;
				measTemp <= 8'h01;
			end
		end
		host.stop();
	endtask

	task automatic t_defaults();
		rdCheck(8'h00, dflt, -1);
		chk8("mode port", 8'h0b, modeReg);
		chk8("control port", 8'h11, ctrlReg);
	endtask

	task automatic t_refused();
		wrRegs(7'h70, 8'h18, {8'hff, 8'hff, 8'hff}, 1'b1);
		wrRegs(7'h70, 8'h06, {8'h12}, 1'b1);
		wrRegs(7'h70, 8'h1f, {8'h5a}, 1'b1);
		rdCheck(8'h18, {TB_PART_ID, 8'h00, 8'h00}, -1);
		rdCheck(8'h06, {8'h00}, -1);
		rdCheck(8'h1f, {8'h00, 8'h00}, -1);
	endtask

	task automatic t_burst();
		wrRegs(7'h70, 8'h2e, {8'h11, 8'h22, 8'h33, 8'h44}, 1'b1);
		rdCheck(8'h2e, {8'h11, 8'h22, 8'h33, 8'h44}, -1);
		wrRegs(7'h70, 8'h02, {8'h00, 8'h80}, 1'b1);
		wrRegs(7'h70, 8'h0b, {8'h34, 8'h12}, 1'b1);
		rdCheck(8'h02, {8'h00, 8'h80}, -1);
		rdCheck(8'h0b, {8'h34, 8'h12}, -1);
		wrRegs(7'h70, 8'h00, {8'h09}, 1'b1);
		chk8("mode port", 8'h09, modeReg);
	endtask

	task automatic t_wrong_addr();
		wrRegs(7'h71, 8'h13, {8'h99}, 1'b0);
		rdCheck(8'h13, {8'h02}, -1);
	endtask

	task automatic t_spike();
		host.spike = 1'b1;
		wrRegs(7'h70, 8'h21, {8'ha5}, 1'b1);
		host.spike = 1'b0;
		rdCheck(8'h21, {8'ha5}, -1);
	endtask

	task automatic t_snapshot();
		measCount <= 16'h1234;
		measCurrent <= 16'hfedc;
		measVoltage <= 16'h0567;
		measTemp <= 8'hf6;
		measValid <= 1'b1;
		repeat (8) @(posedge clk);
		rdCheck(8'h04, {8'h34, 8'h12, 8'hdc, 8'hfe, 8'h67, 8'h05, 8'hf6},
			2);
		rdCheck(8'h08, {8'had, 8'h0b, 8'h01}, -1);
		measValid <= 1'b0;
	endtask

	task automatic t_soft_reset();
		int p;
		wrRegs(7'h70, 8'h13, {8'h55}, 1'b1);
		p = pulses;
		wrRegs(7'h70, 8'h01, {8'h10}, 1'b1);
		chkBit("soft reset pulse", 1'b1, pulses == p + 1);
		chk8("control port", 8'h11, ctrlReg);
		rdCheck(8'h13, {8'h02}, -1);
		wrRegs(7'h70, 8'h01, {8'h01}, 1'b1);
		chk8("control port", 8'h01, ctrlReg);
	endtask

	// frozen port must neither answer nor store anything
	task automatic t_freeze();
		ce <= 1'b0;
		wrRegs(7'h70, 8'h14, {8'h33}, 1'b0);
		ce <= 1'b1;
		rdCheck(8'h14, {8'haa}, -1);
	endtask

	task automatic tally_and_finish();
		if (num_errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		rst_b = 1'b0;
		ce = 1'b1;
		measValid = 1'b0;
		measCount = 16'h0000;
		measCurrent = 16'h0000;
		measVoltage = 16'h0000;
		measTemp = 8'h00;
		relaxCount = 8'h33;
		ccAdjust = 16'h2468;
		vmAdjust = 16'h1357;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		t_defaults();
		t_refused();
		t_burst();
		t_wrong_addr();
		t_spike();
		t_snapshot();
		t_soft_reset();
		t_freeze();
		tally_and_finish();
	end

	initial
	begin
		repeat (80000) @(posedge clk);
		num_errors++;
		tally_and_finish();
	end
endmodule // tb_top

bind ggp_i2c_port ggp_i2c_port_asserts u_chk (.clk(clk), .rst_b(rst_b),
	.sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
	.measReady(measReady), .modeReg(modeReg), .ctrlReg(ctrlReg),
	.softResetPulse(softResetPulse));
`default_nettype wire
